// *** rtl/asr_host.sv ***
// host controller driving an asynchronous 512k x 8 static memory
`timescale 1ns/1ns
`default_nettype none
// Function
// - read keeps read/write high, selects low
// - write framed by read/write line low
// - write may be framed by chip select
// - never drive data while memory drives
// - cycles spaced at least 70 ns
// - select low 60 ns before write ends
// - deselect before retention, wait 5 ms after
module asr_host #(
  parameter int RECOVERY_CYCLES = asr_pkg::RECOVERY_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [asr_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [asr_pkg::DATA_W-1:0] reqWdata,
  output logic rspValid,
  output logic [asr_pkg::DATA_W-1:0] rspRdata,
  input wire logic retainReq,
  output logic retainActive,
  output logic [asr_pkg::ADDR_W-1:0] word_address,
  output logic selectN,
  output logic outEnableN,
  output logic readWriteN,
  input wire logic [asr_pkg::DATA_W-1:0] data_lines_in,
  output logic [asr_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe
);
  localparam logic [asr_pkg::CNT_W-1:0] READ_N =
    asr_pkg::CNT_W'(asr_pkg::READ_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] WRITE_N =
    asr_pkg::CNT_W'(asr_pkg::WRITE_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] FLOAT_N =
    asr_pkg::CNT_W'(asr_pkg::FLOAT_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] GAP_N =
    asr_pkg::CNT_W'(asr_pkg::GAP_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] SYNC_N =
    asr_pkg::CNT_W'(asr_pkg::SYNC_STAGES);
  localparam logic [31:0] RECOVER_N = 32'(RECOVERY_CYCLES);

  asr_pkg::asr_state_t state_r, state_nxt;
  logic [asr_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [31:0] recCnt_r, recCnt_nxt;
  logic [asr_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [asr_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
  logic [asr_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [asr_pkg::DATA_W-1:0] pinSync1_r, pinSync2_r;
  logic sel_r, sel_nxt, oe_r, oe_nxt, rw_r, rw_nxt;
  logic drv_r, drv_nxt, rsp_r, rsp_nxt;

  assign reqReady = (state_r == asr_pkg::ASR_IDLE) && !retainReq;
  assign retainActive = (state_r == asr_pkg::ASR_RET);
  assign rspValid = rsp_r;
  assign rspRdata = rdata_r;
  assign word_address = addr_r;
  assign selectN = sel_r;
  assign outEnableN = oe_r;
  assign readWriteN = rw_r;
  assign data_lines_out = wdata_r;
  assign data_lines_oe = drv_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    recCnt_nxt = recCnt_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    sel_nxt = sel_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    drv_nxt = drv_r;
    rsp_nxt = 1'b0;
    case (state_r)
      asr_pkg::ASR_IDLE: begin
        if (retainReq) begin
          sel_nxt = 1'b1;
          state_nxt = asr_pkg::ASR_RET;
        end else if (reqValid) begin
          addr_nxt = reqAddr;
          cnt_nxt = '0;
          sel_nxt = 1'b0;
          if (reqWrite) begin
            // oe stays high so memory never drives during write
            oe_nxt = 1'b1;
            rw_nxt = 1'b0;
            wdata_nxt = reqWdata;
            state_nxt = asr_pkg::ASR_WR;
          end else begin
            oe_nxt = 1'b0;
            rw_nxt = 1'b1;
            state_nxt = asr_pkg::ASR_RD;
          end
        end
      end
      asr_pkg::ASR_RD: begin
        cnt_nxt = cnt_r + 1'b1;
        // pins settle, then must pass both synchroniser stages
        if (cnt_r + 1'b1 >= READ_N + SYNC_N) begin
          rdata_nxt = pinSync2_r;
          rsp_nxt = 1'b1;
          sel_nxt = 1'b1;
          oe_nxt = 1'b1;
          cnt_nxt = '0;
          state_nxt = asr_pkg::ASR_GAP;
        end
      end
      asr_pkg::ASR_WR: begin
        cnt_nxt = cnt_r + 1'b1;
        // data driven only once outputs have floated
        if (cnt_r + 1'b1 >= FLOAT_N) drv_nxt = 1'b1;
        if (cnt_r + 1'b1 >= WRITE_N + FLOAT_N) begin
          rw_nxt = 1'b1;
          sel_nxt = 1'b1;
          rsp_nxt = 1'b1;
          state_nxt = asr_pkg::ASR_WR_END;
        end
      end
      asr_pkg::ASR_WR_END: begin
        drv_nxt = 1'b0; // zero data hold, release after edge
        cnt_nxt = '0;
        state_nxt = asr_pkg::ASR_GAP;
      end
      asr_pkg::ASR_GAP: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r + 1'b1 >= GAP_N) state_nxt = asr_pkg::ASR_IDLE;
      end
      asr_pkg::ASR_RET: begin
        if (!retainReq) begin
          recCnt_nxt = '0;
          state_nxt = asr_pkg::ASR_RECOVER;
        end
      end
      asr_pkg::ASR_RECOVER: begin
        recCnt_nxt = recCnt_r + 1'b1;
        if (recCnt_r + 1'b1 >= RECOVER_N) begin
          state_nxt = asr_pkg::ASR_IDLE;
        end
      end
      default: state_nxt = asr_pkg::ASR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= asr_pkg::ASR_IDLE;
      cnt_r <= '0;
      recCnt_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      sel_r <= 1'b1;
      oe_r <= 1'b1;
      rw_r <= 1'b1;
      drv_r <= 1'b0;
      rsp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      recCnt_r <= recCnt_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      sel_r <= sel_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      drv_r <= drv_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // two-stage synchroniser on the data pins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pinSync1_r <= '0;
      pinSync2_r <= '0;
    end else begin
      pinSync1_r <= data_lines_in;
      pinSync2_r <= pinSync1_r;
    end
  end

  AST_NO_DRIVE_WHILE_READ: assert property (@(posedge clk_sys)
    disable iff (!reset_n) data_lines_oe |->
    outEnableN && $past(outEnableN) && (!readWriteN || selectN))
    else $error("data driven while memory may drive");
  AST_WRITE_SELECT_LOW: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    $rose(readWriteN) |-> !$past(selectN, 1) && !$past(selectN, 2))
    else $error("select not low long enough before write end");
  AST_READ_LINE_HIGH: assert property (@(posedge clk_sys)
    disable iff (!reset_n) !outEnableN |-> readWriteN && !selectN)
    else $error("read cycle without read line high");
  AST_GAP_AFTER_CYCLE: assert property (@(posedge clk_sys)
    disable iff (!reset_n) $rose(selectN) |=> selectN)
    else $error("cycle spacing violated");
  AST_RSP_PULSE: assert property (@(posedge clk_sys)
    disable iff (!reset_n) rspValid |=> !rspValid)
    else $error("response longer than one cycle");
  AST_READ_WAIT: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    $fell(outEnableN) |-> (!outEnableN && !rspValid) [*3] ##1 rspValid)
    else $error("read data taken too early");
  AST_RET_DESELECT: assert property (@(posedge clk_sys)
    disable iff (!reset_n) retainActive |-> selectN)
    else $error("retention while selected");
  AST_WRITE_OE_HIGH: assert property (@(posedge clk_sys)
    disable iff (!reset_n) !readWriteN |-> outEnableN)
    else $error("output enable low during write");
  AST_IDLE_STANDBY: assert property (@(posedge clk_sys)
    disable iff (!reset_n) reqReady |-> selectN && !data_lines_oe)
    else $error("idle but selected");
endmodule // asr_host
`default_nettype wire

// *** rtl/asr_pkg.sv ***
// constants for the static memory host controller
package asr_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 100;
  localparam int READ_CYCLE_TIME_NS = 70;
  localparam int SELECT_ACCESS_TIME_NS = 70;
  localparam int OUTPUT_DRIVE_ACCESS_TIME_NS = 35;
  localparam int WRITE_TO_FLOAT_TIME_NS = 25;
  localparam int DESELECT_TO_FLOAT_TIME_NS = 25;
  localparam int SELECT_TO_WRITE_END_TIME_NS = 60;
  localparam int RETENTION_RECOVERY_TIME_NS = 5000000;
  // least times round up, at least one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int READ_CYC = cyc_up(SELECT_ACCESS_TIME_NS);
  localparam int WRITE_CYC = cyc_up(SELECT_TO_WRITE_END_TIME_NS);
  localparam int FLOAT_CYC = cyc_up(DESELECT_TO_FLOAT_TIME_NS);
  localparam int GAP_CYC = cyc_up(READ_CYCLE_TIME_NS);
  localparam int RECOVERY_CYC = cyc_up(RETENTION_RECOVERY_TIME_NS);
  localparam int CNT_W = 16;
  // flip-flop stages between the data pins and any logic
  localparam int SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    ASR_IDLE, ASR_RD, ASR_WR, ASR_WR_END, ASR_GAP, ASR_RET, ASR_RECOVER
  } asr_state_t;
endpackage

// *** testbench/asr_mem_model.sv ***
// behavioural model of the 512k x 8 static memory
`timescale 1ns/1ns
`default_nettype none
module asr_mem_model (
  input wire logic clk_sys,
  input wire logic [18:0] word_address,
  input wire logic selectN,
  input wire logic outEnableN,
  input wire logic readWriteN,
  input wire logic [7:0] hostData,
  output logic [7:0] memData
);
  logic [7:0] mem [logic [18:0]];
  logic [7:0] lastQ = 8'h5A;
  logic [7:0] wd;
  logic [18:0] wa;
  logic armed = 1'b0;
  logic drv;
  localparam int ACCESS_NS = 70;
  localparam int FLOAT_NS = 25;
  // drives only in read mode, valid one access time after select
  // released lines show a changing pattern
  assign #(ACCESS_NS, FLOAT_NS) drv = !selectN
    && !outEnableN
    && readWriteN;
  always @* begin
    if (!drv)
      memData = ~lastQ;
    else if (mem.exists(word_address))
      memData = mem[word_address];
    else
      memData = 8'h00;
  end
  always @(posedge clk_sys) lastQ <= memData;
  always @* if (!selectN && !readWriteN) begin
    armed = 1'b1;
    wa = word_address;
    wd = hostData;
  end
  // write ends on whichever control rises first
  always @(posedge selectN or posedge readWriteN)
    if (armed) begin
    mem[wa] = wd;
    armed = 1'b0;
  end
endmodule // asr_mem_model
`default_nettype wire

// *** testbench/asr_host_tb.sv ***
// self-checking bench for the static memory host controller
`timescale 1ns/1ns
`default_nettype none
module asr_host_tb;
  logic clk_sys = 1'b0, reset_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
  logic retainReq = 1'b0;
  logic [18:0] reqAddr = 19'h00000;
  logic [7:0] reqWdata = 8'h00;
  logic reqReady, rspValid, retainActive, selectN, outEnableN, readWriteN;
  logic oe;
  logic [7:0] rspRdata, dOut, memData, dIn;
  logic [18:0] word_address;
  logic [8:0] expQ [$];
  logic [7:0] shadow [logic [18:0]];
  int err_count = 0, num_checks = 0, cyc = 0;
  localparam int REC_CYC = 4;
  asr_host #(.RECOVERY_CYCLES(REC_CYC)) DUT (.clk_sys(clk_sys),
    .reset_n(reset_n),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .rspValid(rspValid),
    .rspRdata(rspRdata), .retainReq(retainReq), .retainActive(retainActive),
    .word_address(word_address), .selectN(selectN), .outEnableN(outEnableN),
    .readWriteN(readWriteN), .data_lines_in(dIn), .data_lines_out(dOut),
    .data_lines_oe(oe));
  asr_mem_model mem (.clk_sys(clk_sys), .word_address(word_address),
    .selectN(selectN), .outEnableN(outEnableN), .readWriteN(readWriteN),
    .hostData(dOut), .memData(memData));
  assign dIn = oe ? dOut : memData;
  initial forever #50 clk_sys = ~clk_sys;
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (!ok) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [18:0] a,
    input logic [7:0] d);
    @(posedge clk_sys);
    #5;
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqWdata = d;
    // ready settled here holds until the next edge, which takes it
    while (reqReady !== 1'b1) begin
      @(posedge clk_sys);
      #5;
    end
    @(posedge clk_sys);
    if (wr) shadow[a] = d;
    expQ.push_back({wr, (wr || !shadow.exists(a)) ? 8'h00 : shadow[a]});
    #5;
    reqValid = 1'b0;
  endtask
  // outputs looked at mid-cycle, where they are settled
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
    if (reset_n && oe && !selectN && !outEnableN && readWriteN)
      check(1'b0, "host drives while memory drives");
    if (rspValid === 1'b1) begin
      if (expQ.size() == 0)
        check(1'b0, "unexpected response");
      else if (!expQ[0][8])
        check(rspRdata === expQ[0][7:0], "rd data");
      if (expQ.size() != 0) void'(expQ.pop_front());
    end
  end
  initial begin
    int n;
    logic [18:0] a;
    void'($urandom(32'h26e9));
    repeat (16) @(posedge clk_sys);
    #5 reset_n = 1'b1;
    // boundary addresses, back-to-back requests
    xfer(1'b1, 19'h00000, 8'hA5);
    xfer(1'b1, 19'h7FFFF, 8'h3C);
    xfer(1'b0, 19'h00000, 8'h00);
    xfer(1'b0, 19'h7FFFF, 8'h00);
    $display("test boundary done");
    for (int i = 0; i < 40; i++) begin
      a = 19'($urandom());
      xfer(1'($urandom()), a[18:0], 8'($urandom()));
    end
    $display("test random done");
    // retention: deselect, refuse, recover
    @(posedge clk_sys);
    #5 retainReq = 1'b1;
    repeat (10) @(posedge clk_sys);
    #5;
    check(retainActive === 1'b1 && selectN === 1'b1, "retention");
    check(reqReady === 1'b0, "ready in retention");
    retainReq = 1'b0;
    n = 0;
    // one cycle to leave retention, then the full recovery count
    while (reqReady !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #5;
      n++;
    end
    check(n == REC_CYC + 1, "recovery wait");
    xfer(1'b0, 19'h00000, 8'h00);
    $display("test retention done");
    repeat (10) @(posedge clk_sys);
    check(expQ.size() == 0, "missing responses");
    stop_test();
  end
endmodule // asr_host_tb
`default_nettype wire
